// ===== hw/tpd_pkg.sv
package tpd_pkg;
  // Number of half-bridges
  localparam int TPD_PHASES = 3;
  // Scheme codes
  typedef enum logic [1:0] {
    TPD_MODE_SIX = 2'b00,
    TPD_MODE_THREE = 2'b01,
    TPD_MODE_SINGLE = 2'b10,
    TPD_MODE_INDEP = 2'b11
  } tpd_mode_t;
  // Commutation state codes at direction 0 (state_bit_a, b, c)
  localparam logic [2:0] TPD_CODE_STOP = 3'h0;
  localparam logic [2:0] TPD_CODE_ALIGN = 3'h7;
  localparam logic [2:0] TPD_CODE_S1 = 3'h6;
  localparam logic [2:0] TPD_CODE_S2 = 3'h4;
  localparam logic [2:0] TPD_CODE_S3 = 3'h5;
  localparam logic [2:0] TPD_CODE_S4 = 3'h1;
  localparam logic [2:0] TPD_CODE_S5 = 3'h3;
  localparam logic [2:0] TPD_CODE_S6 = 3'h2;
  // Synchroniser depth and latency from pin to gate
  localparam int TPD_SYNC_STAGES = 2;
  localparam int TPD_LATENCY = 3;
  // Reset value of gate enables
  localparam logic [2:0] TPD_GATE_RST = 3'h0;
  // Per-phase input pair
  typedef struct packed {
    logic high;
    logic low;
  } tpd_pin_pair_t;
  // Gate enables, index 0 is phase A
  typedef struct packed {
    logic [2:0] high;
    logic [2:0] low;
  } tpd_gates_t;
endpackage

// ===== hw/tpd_sync.sv
`timescale 1ns/100ps
// Two-flop synchroniser for a bus of pin inputs
module tpd_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] q_r;

  // First stage feeds only the second
  always_ff @(posedge clk) begin
    if (srst) begin
      meta_r <= '0;
      q_r <= '0;
    end else begin
      meta_r <= d;
      q_r <= meta_r;
    end
  end

  assign q = q_r;
endmodule // tpd_sync

// ===== hw/tpd_decoder.sv
`timescale 1ns/100ps
// Behaviour
// [R1] Controller drops all inputs to 0 before changing the scheme.
// [R2] Scheme 00 is six-input mode: low, high or floating per phase.
// [R3] Six-input: lone high turns high gate, lone low turns low gate, else off.
// [R4] Scheme 01 is three-input mode; low input only forces floating.
// [R5] Three-input: low 0 all off; else high input picks high or low gate.
// [R6] Without floating need, system holds all low inputs at 1.
// [R7] Scheme 10 is block commutation; phase A high input is the PWM.
// [R8] Single-PWM: A-low, B-high, B-low pins are the three state bits.
// [R9] Synchronous rectification by default; freewheel select gives diode freewheeling.
// [R10] Phase C high picks direction; 1 inverts numbered state codes only.
// [R11] Phase C low at 0 brakes: all low gates on, highs off, overrides.
// [R12] Code 000 all off; 111 aligns: A PWM, B and C low on.
// [R13] Six states drive PWM phase and one held-low phase; third phase off.
// [R14] Asynchronous mode keeps the PWM phase low gate off.
// [R15] Scheme 11 passes each input straight to its gate.
// [R16] Inputs synchronised; gates follow within two cycles; all off in reset. The gates here follow three cycles after the pins.
module tpd_decoder
  import tpd_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Configuration
  input wire tpd_mode_t pwm_scheme,
  input wire logic freewheel_select,
  // Controller pins, index 0 is phase A
  input wire logic [2:0] phase_high_input,
  input wire logic [2:0] phase_low_input,
  // Gate enables
  output logic [2:0] high_gate_enable,
  output logic [2:0] low_gate_enable
);
  logic [5:0] pins_sync;
  logic [2:0] hi_s;
  logic [2:0] lo_s;
  tpd_gates_t gates_nxt;
  tpd_gates_t gates_r;
  logic single_pwm_input;
  logic state_bit_a;
  logic state_bit_b;
  logic state_bit_c;
  logic rotation_direction;
  logic brake_request_n;
  logic [2:0] code;
  logic [1:0] pwm_ph;
  logic [1:0] low_ph;
  logic step_on;

  // Pin synchronisers [R16]
  tpd_sync #(.WIDTH(6)) u_sync (
    .clk(clk),
    .srst(srst),
    .d({phase_high_input, phase_low_input}),
    .q(pins_sync)
  );
  assign hi_s = pins_sync[5:3];
  assign lo_s = pins_sync[2:0];

  // Single-PWM pin roles [R7] [R8] [R10] [R11]
  assign single_pwm_input = hi_s[0];
  assign state_bit_a = lo_s[0];
  assign state_bit_b = hi_s[1];
  assign state_bit_c = lo_s[1];
  assign rotation_direction = hi_s[2];
  assign brake_request_n = lo_s[2];

  // Numbered codes inverted at direction 1, stop and align kept [R10]
  always_comb begin
    code = {state_bit_a, state_bit_b, state_bit_c};
    if (rotation_direction && code != TPD_CODE_STOP && code != TPD_CODE_ALIGN) begin
      code = ~code;
    end
  end

  // Commutation table: PWM phase and held-low phase [R13]
  always_comb begin
    step_on = 1'b1;
    pwm_ph = 2'd0;
    low_ph = 2'd0;
    case (code)
      TPD_CODE_S1: begin
        pwm_ph = 2'd1;
        low_ph = 2'd2;
      end
      TPD_CODE_S2: begin
        pwm_ph = 2'd0;
        low_ph = 2'd2;
      end
      TPD_CODE_S3: begin
        pwm_ph = 2'd0;
        low_ph = 2'd1;
      end
      TPD_CODE_S4: begin
        pwm_ph = 2'd2;
        low_ph = 2'd1;
      end
      TPD_CODE_S5: begin
        pwm_ph = 2'd2;
        low_ph = 2'd0;
      end
      TPD_CODE_S6: begin
        pwm_ph = 2'd1;
        low_ph = 2'd0;
      end
      default: begin
        step_on = 1'b0;
      end
    endcase
  end

  // Gate decode per scheme
  always_comb begin
    gates_nxt = '0;
    case (pwm_scheme)
      TPD_MODE_SIX: begin
        gates_nxt.high = hi_s & ~lo_s; // [R2] [R3]
        gates_nxt.low = lo_s & ~hi_s; // [R3]
      end
      TPD_MODE_THREE: begin
        gates_nxt.high = lo_s & hi_s; // [R4] [R5]
        gates_nxt.low = lo_s & ~hi_s; // [R5]
      end
      TPD_MODE_SINGLE: begin
        if (!brake_request_n) begin
          gates_nxt.low = 3'h7; // [R11]
        end else if (code == TPD_CODE_ALIGN) begin
          gates_nxt.high[0] = single_pwm_input; // [R12]
          gates_nxt.low[0] = !freewheel_select && !single_pwm_input; // [R9] [R14]
          gates_nxt.low[2:1] = 2'b11; // [R12]
        end else if (step_on) begin
          gates_nxt.high[pwm_ph] = single_pwm_input; // [R13]
          gates_nxt.low[pwm_ph] = !freewheel_select && !single_pwm_input; // [R9] [R14]
          gates_nxt.low[low_ph] = 1'b1; // [R13]
        end
      end
      TPD_MODE_INDEP: begin
        gates_nxt.high = hi_s; // [R15]
        gates_nxt.low = lo_s; // [R15]
      end
      default: begin
        gates_nxt = '0;
      end
    endcase
  end

  // Registered gate enables, all off in reset [R16]
  always_ff @(posedge clk) begin
    if (srst) begin
      gates_r <= {TPD_GATE_RST, TPD_GATE_RST};
    end else begin
      gates_r <= gates_nxt;
    end
  end

  assign high_gate_enable = gates_r.high;
  assign low_gate_enable = gates_r.low;

  // Helper: pins, not config, delayed three cycles to match the pipeline
  logic [2:0] hi_d1, hi_d2, hi_d3, lo_d1, lo_d2, lo_d3;
  always_ff @(posedge clk) begin
    hi_d1 <= phase_high_input;
    hi_d2 <= hi_d1;
    hi_d3 <= hi_d2;
    lo_d1 <= phase_low_input;
    lo_d2 <= lo_d1;
    lo_d3 <= lo_d2;
  end

  property p_reset_off;
    @(posedge clk) srst |=> (high_gate_enable == 3'h0 && low_gate_enable == 3'h0);
  endproperty
  a_reset_off: assert property (p_reset_off) else $error("gates on after reset"); // [R16]

  sequence s_quiet;
    !srst [*4];
  endsequence

  property p_six;
    @(posedge clk) disable iff (srst)
      s_quiet ##0 (pwm_scheme == TPD_MODE_SIX && $stable(pwm_scheme))
      |-> high_gate_enable == (hi_d3 & ~lo_d3) && low_gate_enable == (lo_d3 & ~hi_d3);
  endproperty
  a_six: assert property (p_six) else $error("six-input decode wrong"); // [R3]

  property p_three;
    @(posedge clk) disable iff (srst)
      s_quiet ##0 (pwm_scheme == TPD_MODE_THREE && $stable(pwm_scheme))
      |-> high_gate_enable == (hi_d3 & lo_d3) && low_gate_enable == (lo_d3 & ~hi_d3);
  endproperty
  a_three: assert property (p_three) else $error("three-input decode wrong"); // [R5]

  property p_indep;
    @(posedge clk) disable iff (srst)
      s_quiet ##0 (pwm_scheme == TPD_MODE_INDEP && $stable(pwm_scheme))
      |-> high_gate_enable == hi_d3 && low_gate_enable == lo_d3;
  endproperty
  a_indep: assert property (p_indep) else $error("independent mode wrong"); // [R15]

  property p_brake;
    @(posedge clk) disable iff (srst)
      (pwm_scheme == TPD_MODE_SINGLE && !brake_request_n)
      |=> high_gate_enable == 3'h0 && low_gate_enable == 3'h7;
  endproperty
  a_brake: assert property (p_brake) else $error("brake not applied"); // [R11]

  property p_stop;
    @(posedge clk) disable iff (srst)
      (pwm_scheme == TPD_MODE_SINGLE && brake_request_n && code == TPD_CODE_STOP)
      |=> high_gate_enable == 3'h0 && low_gate_enable == 3'h0;
  endproperty
  a_stop: assert property (p_stop) else $error("stop code drives gates"); // [R12]

  property p_align;
    @(posedge clk) disable iff (srst)
      (pwm_scheme == TPD_MODE_SINGLE && brake_request_n && code == TPD_CODE_ALIGN)
      |=> high_gate_enable == {2'b00, $past(single_pwm_input)} && low_gate_enable[2:1] == 2'b11;
  endproperty
  a_align: assert property (p_align) else $error("align gates wrong"); // [R12]

  property p_async_low_off;
    @(posedge clk) disable iff (srst)
      (pwm_scheme == TPD_MODE_SINGLE && freewheel_select && brake_request_n && step_on)
      |=> low_gate_enable[$past(pwm_ph)] == 1'b0 && low_gate_enable[$past(low_ph)];
  endproperty
  a_async_low_off: assert property (p_async_low_off) else $error("freewheel low gate on"); // [R14]

  property p_sync_comp;
    @(posedge clk) disable iff (srst)
      (pwm_scheme == TPD_MODE_SINGLE && !freewheel_select && brake_request_n && step_on)
      |=> low_gate_enable[$past(pwm_ph)] != high_gate_enable[$past(pwm_ph)];
  endproperty
  a_sync_comp: assert property (p_sync_comp) else $error("no synchronous rectification"); // [R9]

  property p_dir;
    @(posedge clk) disable iff (srst)
      (rotation_direction && {state_bit_a, state_bit_b, state_bit_c} == TPD_CODE_S1)
      |-> code == ~TPD_CODE_S1;
  endproperty
  a_dir: assert property (p_dir) else $error("direction inversion wrong"); // [R10]
endmodule // tpd_decoder

// ===== bench/tpd_ctrl_model.sv
`timescale 1ns/100ps
// Controller model that owns the pins and the scheme selection
module tpd_ctrl_model
  import tpd_pkg::*;
(
  // Clock
  input wire logic clk,
  // Requests from the bench
  input wire tpd_mode_t mode_req,
  input wire logic [2:0] high_req,
  input wire logic [2:0] low_req,
  input wire logic float_en,
  // Toward the driver, and busy toward the bench
  output tpd_mode_t pwm_scheme,
  output logic [2:0] phase_high_input,
  output logic [2:0] phase_low_input,
  output logic busy
);
  int quiet = 0;
  assign busy = (mode_req != pwm_scheme);
  // Known pin levels from time zero
  initial begin
    pwm_scheme = TPD_MODE_SIX;
    phase_high_input = 3'h0;
    phase_low_input = 3'h0;
  end
  // Park all pins for a while before a scheme change; requests are read at the edge
  always @(posedge clk) begin
    if (busy) begin
      phase_high_input <= 3'h0;
      phase_low_input <= 3'h0;
      quiet <= (quiet >= 4) ? 0 : quiet + 1;
      if (quiet >= 4) begin
        pwm_scheme <= mode_req;
      end
    end else begin
      phase_high_input <= high_req;
      phase_low_input <= (mode_req == TPD_MODE_THREE && !float_en) ? 3'h7 : low_req;
    end
  end
endmodule // tpd_ctrl_model

// ===== bench/three_phase_pwm_input_decoder_bench.sv
`timescale 1ns/100ps
// Self-checking bench for the gate input decoder
module three_phase_pwm_input_decoder_bench;
  import tpd_pkg::*;
  logic clk, srst, fw, flt, busy;
  tpd_mode_t mode_req, pwm_scheme;
  logic [2:0] hreq, lreq, hi, lo, hg, lg;
  int n_mismatch = 0;
  int n_tests = 0;

  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  tpd_decoder dut_u (.clk(clk), .srst(srst), .pwm_scheme(pwm_scheme), .freewheel_select(fw),
    .phase_high_input(hi), .phase_low_input(lo), .high_gate_enable(hg), .low_gate_enable(lg));
  tpd_ctrl_model ctrl_u (.clk(clk), .mode_req(mode_req), .high_req(hreq), .low_req(lreq),
    .float_en(flt), .pwm_scheme(pwm_scheme), .phase_high_input(hi), .phase_low_input(lo),
    .busy(busy));

  // Expected gates {high, low} from scheme and pin levels
  function automatic logic [5:0] exp_g(tpd_mode_t m, logic f, logic [2:0] h, logic [2:0] l);
    logic [2:0] g, k, c;
    logic [1:0] p, q;
    g = 3'h0;
    k = 3'h0;
    case (m)
      TPD_MODE_SIX: {g, k} = {h & ~l, l & ~h};
      TPD_MODE_THREE: {g, k} = {l & h, l & ~h};
      TPD_MODE_INDEP: {g, k} = {h, l};
      default: begin
        c = {l[0], h[1], l[1]};
        if (h[2] && c != 3'h0 && c != 3'h7) c = ~c;
        // PWM phase and held-low phase per code, 3 means none
        {p, q} = 4'(32'h3612_849f >> (c * 4));
        if (p != 2'h3) g[p] = h[0];
        if (p != 2'h3) k[p] = ~h[0] & ~f;
        if (q != 2'h3) k[q] = 1'b1;
        if (c == 3'h7) k = k | 3'h6;
        if (!l[2]) {g, k} = 6'h07;
      end
    endcase
    return {g, k};
  endfunction

  // Compare and count
  task automatic check(input logic [5:0] seen, input logic [5:0] exp);
    n_tests++;
    if (seen !== exp) begin
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      n_mismatch++;
    end
  endtask

  task automatic report_and_stop;
    $display("Checks %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Request scheme and pins, then check gates at the settled latency
  task automatic apply(input tpd_mode_t m, input logic f, input logic [2:0] h,
    input logic [2:0] l, input logic fe);
    @(posedge clk);
    #1;
    mode_req = m;
    fw = f;
    hreq = h;
    lreq = l;
    flt = fe;
    // Busy follows the request at once; the model takes the pins at the next edge
    @(posedge clk);
    #1;
    for (int i = 0; i < 20 && busy; i++) begin
      @(posedge clk);
      #1;
    end
    if (busy) begin
      n_mismatch++;
      report_and_stop();
    end else begin
      repeat (5) @(posedge clk);
      #1;
      check({hg, lg}, exp_g(pwm_scheme, fw, hi, lo));
    end
  endtask

  // Main sequence
  initial begin
    srst = 1'b1;
    fw = 1'b0;
    flt = 1'b1;
    mode_req = TPD_MODE_SIX;
    hreq = 3'h0;
    lreq = 3'h0;
    repeat (2) @(posedge clk);
    #1;
    check({hg, lg}, 6'h00);
    srst = 1'b0;
    for (int i = 0; i < 8; i++) begin
      apply(TPD_MODE_SIX, 1'b0, i[2:0], i[2:0] ^ 3'h5, 1'b1);
    end
    for (int i = 0; i < 8; i++) begin
      apply(TPD_MODE_THREE, 1'b0, i[2:0], i[2:0] ^ 3'h3, 1'b1);
    end
    apply(TPD_MODE_THREE, 1'b0, 3'h5, 3'h0, 1'b0);
    for (int i = 0; i < 128; i++) begin
      apply(TPD_MODE_SINGLE, i[6], i[2:0], i[5:3], 1'b1);
    end
    for (int i = 0; i < 64; i++) begin
      apply(TPD_MODE_INDEP, 1'b0, i[2:0], i[5:3], 1'b1);
    end
    @(posedge clk);
    #1;
    srst = 1'b1;
    @(posedge clk);
    #1;
    check({hg, lg}, 6'h00);
    srst = 1'b0;
    report_and_stop();
  end
endmodule // three_phase_pwm_input_decoder_bench
